// ---- rtl/standard_timer_module.sv ----
// Functional notes
// - Clock select picks counter tick source.
// - Code 101 supplies no counter clock.
// - Counter runs only while module is on.
// - Turning on clears counter to zero.
// - Turning on restores compare-mode initial output.
// - Period value compared with counter bits 9-7.
// - Period zero lets counter overflow instead.
// - Mode field selects four operating modes.
// - Comparator A match acts per output function.
// - PWM mode output function: force, PWM, pulse.
// - Capture edges rising, falling, both, disabled.
// - Requested level equal initial shows no change.
// - Initial level bit: initial or active level.
// - Invert bit inverts output pins.
// - Swap bit exchanges period and duty sources.
// - Clear select: comparator A or P/overflow.
// - Clear select ignored in PWM and capture.
// - Counter readable as low and high bytes.
// - Comparator A compares all ten counter bits.
// - Pause holds counter, resumes from held value.
// - Each comparator match sets its own flag.
`timescale 1ns/1ps
`default_nettype none
module standard_timer_module (
   // Clock and reset
   input  wire logic       ref_clk,
   input  wire logic       srst,
   // Register port
   input  wire logic [2:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   // Clock sources
   input  wire logic       timebase_clock,
   input  wire logic       external_clock_pin,
   // Output pin a doubles as the capture input
   input  wire logic       output_pin_a_i,
   output logic            output_pin_a_o,
   output logic            output_pin_a_oe_n,
   output logic            output_pin_b_o,
   output logic            output_pin_b_oe_n
);
   logic [7:0] ctrl0_r;
   logic [7:0] ctrl1_r;
   logic [9:0] cmpa_r;
   logic [9:0] cnt_r;
   logic [5:0] div_r;
   logic       on_d_r;
   logic       ext_d_r;
   logic       cap_d_r;
   logic       flag_p_r;
   logic       flag_a_r;
   logic       lvl_r;
   logic       pulse_r;
   logic       pin_r;
   logic [7:0] rdata_r;

   standard_timer_pkg::clk_sel_t clk_sel;
   standard_timer_pkg::op_mode_t mode;
   logic [2:0]  period_val;
   logic [1:0]  out_fn;
   logic        module_on, pause, init_lvl, invert, swap, clr_sel;
   logic        on_rise, src_tick, cnt_tick, p_hit, a_hit, clr_evt, cap_hit;
   logic [9:0]  cnt_inc;
   logic [10:0] duty;
   logic        pwm_lvl, drive_lvl, out_drive;

   assign clk_sel    = standard_timer_pkg::clk_sel_t'(ctrl0_r[standard_timer_pkg::CKSEL_LSB +: 3]);
   assign mode       = standard_timer_pkg::op_mode_t'(ctrl1_r[standard_timer_pkg::MODE_LSB +: 2]);
   assign period_val = ctrl0_r[standard_timer_pkg::PERIOD_LSB +: 3];
   assign module_on  = ctrl0_r[standard_timer_pkg::ON_BIT];
   assign pause      = ctrl0_r[standard_timer_pkg::PAUSE_BIT];
   assign out_fn     = ctrl1_r[standard_timer_pkg::OUTFN_LSB +: 2];
   assign init_lvl   = ctrl1_r[standard_timer_pkg::INIT_BIT];
   assign invert     = ctrl1_r[standard_timer_pkg::INVERT_BIT];
   assign swap       = ctrl1_r[standard_timer_pkg::SWAP_BIT];
   assign clr_sel    = ctrl1_r[standard_timer_pkg::CLRSEL_BIT];
   assign on_rise    = module_on && !on_d_r;

   // Control registers.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         ctrl0_r <= standard_timer_pkg::CTRL0_RST;
         ctrl1_r <= standard_timer_pkg::CTRL1_RST;
      end else if (reg_wr) begin
         if (reg_addr == standard_timer_pkg::CTRL0_ADDR) begin
            ctrl0_r <= reg_wdata;
         end
         if (reg_addr == standard_timer_pkg::CTRL1_ADDR) begin
            ctrl1_r <= reg_wdata;
         end
      end
   end

   // Compare value A; a capture event overwrites it with the counter.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         cmpa_r <= standard_timer_pkg::CMPA_RST;
      end else if (cap_hit) begin
         cmpa_r <= cnt_r;
      end else if (reg_wr && reg_addr == standard_timer_pkg::CMPA_LO_ADDR) begin
         cmpa_r[7:0] <= reg_wdata;
      end else if (reg_wr && reg_addr == standard_timer_pkg::CMPA_HI_ADDR) begin
         cmpa_r[9:8] <= reg_wdata[1:0];
      end
   end

   // Edge history for on bit, external clock and capture input.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         on_d_r  <= 1'b0;
         ext_d_r <= 1'b0;
         cap_d_r <= 1'b0;
         div_r   <= 6'h00;
      end else begin
         on_d_r  <= module_on;
         ext_d_r <= external_clock_pin;
         cap_d_r <= output_pin_a_i;
         div_r   <= div_r + 6'h01;
      end
   end

   // Tick source selection.
   always_comb begin
      case (clk_sel)
         standard_timer_pkg::CK_SYS_DIV4:
            src_tick = (div_r & standard_timer_pkg::DIV4_MASK) == standard_timer_pkg::DIV4_MASK;
         standard_timer_pkg::CK_SYS:      src_tick = 1'b1;
         standard_timer_pkg::CK_HI_DIV16:
            src_tick = (div_r & standard_timer_pkg::DIV16_MASK) == standard_timer_pkg::DIV16_MASK;
         standard_timer_pkg::CK_HI_DIV64: src_tick = div_r == standard_timer_pkg::DIV64_MASK;
         standard_timer_pkg::CK_TIMEBASE: src_tick = timebase_clock;
         standard_timer_pkg::CK_EXT_RISE: src_tick = external_clock_pin && !ext_d_r;
         standard_timer_pkg::CK_EXT_FALL: src_tick = !external_clock_pin && ext_d_r;
         default:                         src_tick = 1'b0;
      endcase
   end

   assign cnt_tick = src_tick && module_on && !pause && !on_rise;
   assign cnt_inc  = cnt_r + 10'h001;

   // Comparator P matches the top three bits with the low seven bits zero; zero means overflow.
   assign p_hit = cnt_tick && ((period_val != 3'h0) ?
                  (cnt_inc[9:7] == period_val && cnt_inc[6:0] == 7'h00) :
                  (cnt_r == standard_timer_pkg::CNT_MAX));
   assign a_hit = cnt_tick && (cnt_inc == cmpa_r);

   // Counter clear source.
   always_comb begin
      case (mode)
         standard_timer_pkg::MODE_PWM:     clr_evt = swap ? a_hit : p_hit;
         standard_timer_pkg::MODE_CAPTURE: clr_evt = 1'b0;
         default:                          clr_evt = clr_sel ? a_hit : p_hit;
      endcase
   end

   // Counter.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         cnt_r <= 10'h000;
      end else if (on_rise) begin
         cnt_r <= 10'h000;
      end else if (cnt_tick) begin
         cnt_r <= clr_evt ? 10'h000 : cnt_inc;
      end
   end

   // Capture edge detection.
   always_comb begin
      case (out_fn)
         2'h0:    cap_hit = output_pin_a_i && !cap_d_r;
         2'h1:    cap_hit = !output_pin_a_i && cap_d_r;
         2'h2:    cap_hit = output_pin_a_i != cap_d_r;
         default: cap_hit = 1'b0;
      endcase
      cap_hit = cap_hit && module_on && (mode == standard_timer_pkg::MODE_CAPTURE);
   end

   // Match flags; set wins over a write-one clear.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         flag_p_r <= 1'b0;
         flag_a_r <= 1'b0;
      end else begin
         if (p_hit) begin
            flag_p_r <= 1'b1;
         end else if (reg_wr && reg_addr == standard_timer_pkg::FLAGS_ADDR
                      && reg_wdata[standard_timer_pkg::FLAG_P_BIT]) begin
            flag_p_r <= 1'b0;
         end
         if (a_hit || cap_hit) begin
            flag_a_r <= 1'b1;
         end else if (reg_wr && reg_addr == standard_timer_pkg::FLAGS_ADDR
                      && reg_wdata[standard_timer_pkg::FLAG_A_BIT]) begin
            flag_a_r <= 1'b0;
         end
      end
   end

   // Compare-mode output level.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         lvl_r <= 1'b0;
      end else if (mode == standard_timer_pkg::MODE_CMP) begin
         if (on_rise) begin
            lvl_r <= init_lvl;
         end else if (a_hit) begin
            case (out_fn)
               2'h1:    lvl_r <= 1'b0;
               2'h2:    lvl_r <= 1'b1;
               2'h3:    lvl_r <= !lvl_r;
               default: lvl_r <= lvl_r;
            endcase
         end
      end
   end

   // Single pulse: active from switch-on until the first period clear.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         pulse_r <= 1'b0;
      end else if (on_rise) begin
         pulse_r <= 1'b1;
      end else if (mode == standard_timer_pkg::MODE_PWM && clr_evt) begin
         pulse_r <= 1'b0;
      end
   end

   // Duty source; a zero period code stands for the full 1024 count.
   assign duty = swap ? {(period_val == 3'h0), period_val, 7'h00} : {1'b0, cmpa_r};

   always_comb begin
      case (out_fn)
         2'h0:    pwm_lvl = !init_lvl;
         2'h1:    pwm_lvl = init_lvl;
         2'h2:    pwm_lvl = ({1'b0, cnt_r} < duty) ? init_lvl : !init_lvl;
         default: pwm_lvl = pulse_r ? init_lvl : !init_lvl;
      endcase
   end

   assign out_drive = (mode == standard_timer_pkg::MODE_CMP) || (mode == standard_timer_pkg::MODE_PWM);
   assign drive_lvl = (mode == standard_timer_pkg::MODE_PWM) ? pwm_lvl : lvl_r;

   // Output pin register with polarity inversion.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         pin_r <= 1'b0;
      end else if (out_drive) begin
         pin_r <= drive_lvl ^ invert;
      end
   end

   assign output_pin_a_o    = pin_r;
   assign output_pin_b_o    = pin_r;
   assign output_pin_a_oe_n = !out_drive;
   assign output_pin_b_oe_n = !out_drive;

   // Register read data, valid only in the cycle after the strobe.
   always_ff @(posedge ref_clk) begin
      if (srst || !reg_rd) begin
         rdata_r <= 8'h00;
      end else begin
         case (reg_addr)
            standard_timer_pkg::CTRL0_ADDR:   rdata_r <= ctrl0_r;
            standard_timer_pkg::CTRL1_ADDR:   rdata_r <= ctrl1_r;
            standard_timer_pkg::CNT_LO_ADDR:  rdata_r <= cnt_r[7:0];
            standard_timer_pkg::CNT_HI_ADDR:  rdata_r <= {6'h00, cnt_r[9:8]};
            standard_timer_pkg::CMPA_LO_ADDR: rdata_r <= cmpa_r[7:0];
            standard_timer_pkg::CMPA_HI_ADDR: rdata_r <= {6'h00, cmpa_r[9:8]};
            standard_timer_pkg::FLAGS_ADDR:   rdata_r <= {6'h00, flag_a_r, flag_p_r};
            default:                          rdata_r <= 8'h00;
         endcase
      end
   end

   assign reg_rdata = rdata_r;

   default clocking dc @(posedge ref_clk); endclocking
   default disable iff (srst);

   AST_OFF_HOLDS: assert property (!module_on |=> $stable(cnt_r))
      else $error("counter moved while off");
   AST_ON_CLEARS: assert property (!module_on ##1 module_on |=> cnt_r == 10'h000)
      else $error("counter not cleared on switch-on");
   AST_UNDEF_CLK: assert property (clk_sel == standard_timer_pkg::CK_UNDEF |-> !cnt_tick)
      else $error("counter ticked on undefined clock");
   AST_SYS_CLK: assert property (module_on && !pause && on_d_r
                                 && clk_sel == standard_timer_pkg::CK_SYS |-> cnt_tick)
      else $error("system clock tick missing");
   AST_PAUSE: assert property (pause && on_d_r |=> cnt_r == $past(cnt_r))
      else $error("counter moved while paused");
   AST_CMP_INIT: assert property (on_rise && mode == standard_timer_pkg::MODE_CMP
                                  |-> ##2 pin_r == ($past(init_lvl, 2) ^ $past(invert, 1)))
      else $error("initial level not restored");
   AST_P_CLEAR: assert property (p_hit && mode == standard_timer_pkg::MODE_TIMER && !clr_sel
                                 |=> cnt_r == 10'h000 && flag_p_r)
      else $error("period match did not clear");
   AST_HI_BYTE: assert property (reg_rd && reg_addr == standard_timer_pkg::CNT_HI_ADDR
                                 |=> reg_rdata == {6'h00, $past(cnt_r[9:8])})
      else $error("high byte read wrong");
   AST_CAPTURE: assert property (cap_hit |=> cmpa_r == $past(cnt_r) && flag_a_r)
      else $error("capture not stored");
   AST_A_FLAG: assert property (a_hit |=> flag_a_r)
      else $error("comparator A flag not set");

   COV_P_MATCH: cover property (p_hit && period_val == 3'h1);
   COV_A_TOGGLE: cover property (a_hit && mode == standard_timer_pkg::MODE_CMP && out_fn == 2'h3);
   COV_CAPTURE: cover property (cap_hit);
   COV_PWM: cover property (mode == standard_timer_pkg::MODE_PWM && out_fn == 2'h2 && clr_evt);
endmodule // standard_timer_module
`default_nettype wire

// ---- rtl/standard_timer_pkg.sv ----
package standard_timer_pkg;
   // Register indices on the byte-wide register port.
   localparam logic [2:0] CTRL0_ADDR    = 3'h0;
   localparam logic [2:0] CTRL1_ADDR    = 3'h1;
   localparam logic [2:0] CNT_LO_ADDR   = 3'h2;
   localparam logic [2:0] CNT_HI_ADDR   = 3'h3;
   localparam logic [2:0] CMPA_LO_ADDR  = 3'h4;
   localparam logic [2:0] CMPA_HI_ADDR  = 3'h5;
   localparam logic [2:0] FLAGS_ADDR    = 3'h6;

   // Control register zero fields.
   localparam int PAUSE_BIT   = 7;
   localparam int CKSEL_LSB   = 4;
   localparam int ON_BIT      = 3;
   localparam int PERIOD_LSB  = 0;
   // Control register one fields.
   localparam int MODE_LSB    = 6;
   localparam int OUTFN_LSB   = 4;
   localparam int INIT_BIT    = 3;
   localparam int INVERT_BIT  = 2;
   localparam int SWAP_BIT    = 1;
   localparam int CLRSEL_BIT  = 0;
   // Flag register fields.
   localparam int FLAG_P_BIT  = 0;
   localparam int FLAG_A_BIT  = 1;

   localparam logic [7:0] CTRL0_RST = 8'h00;
   localparam logic [7:0] CTRL1_RST = 8'h00;
   localparam logic [9:0] CMPA_RST  = 10'h000;
   localparam logic [9:0] CNT_MAX   = 10'h3FF;

   // Prescaler tap masks; the high speed clock is taken to be ref_clk.
   localparam logic [5:0] DIV4_MASK  = 6'h03;
   localparam logic [5:0] DIV16_MASK = 6'h0F;
   localparam logic [5:0] DIV64_MASK = 6'h3F;

   typedef enum logic [2:0] {
      CK_SYS_DIV4 = 3'h0, CK_SYS = 3'h1, CK_HI_DIV16 = 3'h2, CK_HI_DIV64 = 3'h3,
      CK_TIMEBASE = 3'h4, CK_UNDEF = 3'h5, CK_EXT_RISE = 3'h6, CK_EXT_FALL = 3'h7
   } clk_sel_t;

   typedef enum logic [1:0] {
      MODE_CMP = 2'h0, MODE_CAPTURE = 2'h1, MODE_PWM = 2'h2, MODE_TIMER = 2'h3
   } op_mode_t;
endpackage

// ---- bench/pin_partner.sv ----
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
   // Clock
   input  wire logic ref_clk,
   // Pins facing the timer
   output logic      ext_clk,
   output logic      cap_in
);
   initial begin
      ext_clk = 1'b0;
      cap_in  = 1'b0;
   end

   // Full pulses on the count pin; the pin rests low between bursts.
   task automatic pulses(input int n);
      repeat (n) begin
         @(posedge ref_clk);
         ext_clk <= 1'b1;
         repeat (2) @(posedge ref_clk);
         ext_clk <= 1'b0;
         repeat (2) @(posedge ref_clk);
      end
   endtask

   // Moves the capture line to a new level and leaves it settled.
   task automatic cap_to(input logic v);
      @(posedge ref_clk);
      cap_in <= v;
      repeat (4) @(posedge ref_clk);
   endtask
endmodule // pin_partner
`default_nettype wire

// ---- bench/tb_standard_timer_module.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_standard_timer_module;
   logic       ref_clk, srst, reg_wr, reg_rd, timebase_clock, rd_d;
   logic [2:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata;
   logic       ext_clk, cap_in, pin_a, pin_a_o, pin_a_oe_n, pin_b_o, pin_b_oe_n;
   logic [9:0] exp_q[$];
   int         err_count, n_checks, cyc;
   int         divs[4] = '{4, 1, 16, 64};

   // The pad level: the timer when it drives, otherwise the outside circuit.
   assign pin_a = pin_a_oe_n ? cap_in : pin_a_o;

   standard_timer_module dut (
      .ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .timebase_clock(timebase_clock), .external_clock_pin(ext_clk),
      .output_pin_a_i(pin_a), .output_pin_a_o(pin_a_o), .output_pin_a_oe_n(pin_a_oe_n),
      .output_pin_b_o(pin_b_o), .output_pin_b_oe_n(pin_b_oe_n));
   pin_partner p (.ref_clk(ref_clk), .ext_clk(ext_clk), .cap_in(cap_in));

   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up;
      if (err_count == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge ref_clk);
      reg_wr    <= 1'b0;
   endtask

   task automatic rd(input logic [2:0] a, input logic [9:0] e);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge ref_clk);
      reg_rd   <= 1'b0;
      exp_q.push_back(e);
   endtask

   task automatic rdcnt(input logic [9:0] v);
      rd(3'h2, {2'h0, v[7:0]});
      rd(3'h3, {8'h00, v[9:8]});
   endtask

   // Runs the counter for k cycles between the on and off write edges: k-1 counting cycles, one tick each on the system clock.
   task automatic span(input logic [7:0] c0, input int k);
      wr(3'h0, c0 | 8'h08);
      repeat (k - 2) @(posedge ref_clk);
      wr(3'h0, c0);
   endtask

   // Read data stand one cycle after the strobe edge and are compared there.
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (rd_d) chk({2'h0, reg_rdata}, exp_q.pop_front());
      rd_d <= reg_rd;
      if (cyc == 60000) begin
         err_count++;
         wrap_up();
      end
   end

   initial begin
      int n, inv, hc, e;
      logic [7:0] c1;
      logic [9:0] a;
      srst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 3'h0; reg_wdata = 8'h00;
      timebase_clock = 1'b0; rd_d = 1'b0; cyc = 0; err_count = 0; n_checks = 0;
      void'($urandom(41));
      repeat (8) @(posedge ref_clk);
      srst <= 1'b0;
      for (int i = 0; i < 4; i++) rd(3'(i), 10'h000);
      rd(3'h7, 10'h000);
      wr(3'h2, 8'hFF);
      rd(3'h2, 10'h000);
      for (int i = 0; i < 4; i++) begin
         span(8'(i << 4), 1 + 100 * divs[i]);
         rdcnt(10'd100);
      end
      repeat (50) @(posedge ref_clk);
      rdcnt(10'd100);
      span(8'h10, 2);
      rdcnt(10'd1);
      span(8'h50, 200);
      rdcnt(10'd0);
      foreach (divs[j]) if (j < 3) begin
         n = 5 + $urandom % 20;
         c1 = (j == 0) ? 8'h40 : (j == 1) ? 8'h60 : 8'h70;
         wr(3'h0, c1 | 8'h08);
         repeat (4) @(posedge ref_clk);
         if (j == 0) repeat (n) begin
            @(posedge ref_clk) timebase_clock <= 1'b1;
            @(posedge ref_clk) timebase_clock <= 1'b0;
         end
         else p.pulses(n);
         repeat (4) @(posedge ref_clk);
         wr(3'h0, c1);
         rdcnt(10'(n));
      end
      wr(3'h0, 8'h18);
      repeat (48) @(posedge ref_clk);
      wr(3'h0, 8'h98);
      repeat (38) @(posedge ref_clk);
      wr(3'h0, 8'h18);
      repeat (48) @(posedge ref_clk);
      wr(3'h0, 8'h10);
      rdcnt(10'd99);
      for (int r = 0; r < 5; r++) begin
         c1 = (r == 1) ? 8'h01 : (r == 4) ? 8'h81 : 8'h00;
         a = (r == 2) ? 10'd500 : (r == 3) ? 10'd1000 : 10'd50;
         wr(3'h1, c1);
         wr(3'h4, a[7:0]);
         wr(3'h5, {6'h00, a[9:8]});
         wr(3'h6, 8'h03);
         span((r == 2) ? 8'h10 : (r == 3) ? 8'h17 : 8'h11, (r == 2) ? 1100 : (r == 3) ? 1000 : 300);
         rdcnt((r == 1) ? 10'd49 : (r == 2) ? 10'd75 : (r == 3) ? 10'd103 : 10'd43);
         rd(3'h6, (r == 1) ? 10'h2 : (r == 3) ? 10'h1 : 10'h3);
      end
      for (int f = 0; f < 8; f++) begin
         inv = $urandom % 2;
         wr(3'h1, 8'((f >> 1) << 4) | 8'((f & 1) << 3) | 8'(inv << 2));
         wr(3'h4, 8'd20);
         wr(3'h5, 8'h00);
         wr(3'h0, 8'h19);
         repeat (3) @(posedge ref_clk);
         chk(10'(pin_a), 10'((f & 1) ^ inv));
         chk(10'(pin_a_oe_n), 10'h0);
         repeat (27) @(posedge ref_clk);
         e = ((f >> 1) == 0) ? (f & 1) : ((f >> 1) == 1) ? 0 : ((f >> 1) == 2) ? 1 : 1 - (f & 1);
         chk(10'(pin_a), 10'(e ^ inv));
         chk(10'(pin_b_o), 10'(e ^ inv));
         wr(3'h0, 8'h01);
      end
      for (int r = 0; r < 4; r++) begin
         inv = $urandom % 2;
         e = $urandom % 2;
         a = (r == 1) ? 10'd300 : 10'd32;
         wr(3'h1, 8'h80 | 8'((r == 2) ? 0 : (r == 3) ? 16 : 32) | 8'(e << 3)
            | 8'(inv << 2) | 8'((r == 1) << 1));
         wr(3'h4, a[7:0]);
         wr(3'h5, {6'h00, a[9:8]});
         wr(3'h0, 8'h19);
         repeat (200) @(posedge ref_clk);
         hc = 0;
         n = (r == 1) ? 600 : 512;
         repeat (n) @(posedge ref_clk) hc += int'(pin_a_o);
         a = (r == 0) ? 10'd128 : (r == 1) ? 10'd256 : (r == 2) ? 10'd0 : 10'd512;
         if (e == 0) a = 10'(n) - a;
         if (inv == 1) a = 10'(n) - a;
         chk(10'(hc), a);
         wr(3'h0, 8'h10);
      end
      for (int f = 0; f < 4; f++) begin
         wr(3'h1, 8'h40 | 8'(f << 4));
         // Park compare A far above the short count so only capture can raise flag A.
         wr(3'h5, 8'h03);
         wr(3'h6, 8'h03);
         wr(3'h0, 8'h18);
         p.cap_to(1'b1);
         rd(3'h6, (f == 0 || f == 2) ? 10'h2 : 10'h0);
         wr(3'h6, 8'h03);
         p.cap_to(1'b0);
         rd(3'h6, (f == 1 || f == 2) ? 10'h2 : 10'h0);
         chk(10'(pin_a_oe_n), 10'h1);
         wr(3'h0, 8'h10);
      end
      wr(3'h1, 8'hC0);
      repeat (2) @(posedge ref_clk);
      chk(10'(pin_b_oe_n), 10'h1);
      repeat (4) @(posedge ref_clk);
      wrap_up();
   end
endmodule // tb_standard_timer_module
`default_nettype wire
